// file: design/bmrl_pkg.sv
package bmrl_pkg;
    // Memory image geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] USER_FIRST = 12'h000;
    localparam logic [ADDR_W-1:0] USER_LAST = 12'hffd;
    // Registration code word sits two words past the end of the user area
    localparam logic [ADDR_W-1:0] REG_CODE_ADDR = 12'hfff;
    localparam logic [DATA_W-1:0] REG_CODE_VALUE = 16'ha55a;
    localparam logic [DATA_W-1:0] ERASED_VALUE = 16'hffff;
    // Mechanical programs and cam tables occupy the top of the image
    localparam logic [ADDR_W-1:0] MECH_FIRST = 12'hc00;
    // Backup area never copied to flash
    localparam logic [ADDR_W-1:0] BACKUP_FIRST = 12'hf00;
    // Endurance of the flash array
    localparam int WCNT_W = 17;
    localparam logic [WCNT_W-1:0] WRITE_LIMIT = 17'h186a0;
    // FIFO geometry
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_PTR_W = 3;
    // Mode indicator colour codes
    localparam logic [1:0] IND_OFF = 2'h0;
    localparam logic [1:0] IND_GREEN = 2'h1;
    localparam logic [1:0] IND_ORANGE = 2'h2;

    typedef enum logic [1:0] {
        MODE_INSTALL,
        MODE_RAM,
        MODE_ROM
    } bmrl_mode_t;
endpackage

// file: design/bmrl_fifo.sv
`timescale 1ns/100ps
module bmrl_fifo
    import bmrl_pkg::*;
#(
    parameter int WIDTH = 28,
    parameter int DEPTH = 8,
    parameter int PTR_W = 3
) (
    // Clocking
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [PTR_W-1:0] wp;
        logic [PTR_W-1:0] rp;
        logic [PTR_W:0] cnt;
    } bmrl_fifo_st_t;

    bmrl_fifo_st_t s_r;
    bmrl_fifo_st_t s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (s_r.cnt != DEPTH[PTR_W:0]);
    assign out_valid = (s_r.cnt != '0);
    assign out_data = mem[s_r.rp];
    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;

    always_comb begin
        s_nxt = s_r;
        if (flush) begin
            s_nxt = '0;
        end else begin
            if (push) s_nxt.wp = s_r.wp + 1'b1;
            if (pop) s_nxt.rp = s_r.rp + 1'b1;
            if (push && !pop) s_nxt.cnt = s_r.cnt + 1'b1;
            else if (pop && !push) s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) s_r <= '0;
        else if (clk_en) s_r <= s_nxt;
    end

    // Storage needs no reset
    always_ff @(posedge sys_clk) begin
        if (clk_en && push) mem[s_r.wp] <= in_data;
    end
endmodule

// file: design/bmrl_mode_decode.sv
`timescale 1ns/100ps
module bmrl_mode_decode
    import bmrl_pkg::*;
(
    // Switches
    input wire logic rom_select_a_switch,
    input wire logic rom_select_b_switch,
    input wire logic install_enable_switch,
    // Decoded mode
    output bmrl_mode_t mode
);
    always_comb begin
        if (install_enable_switch) mode = MODE_INSTALL;
        else if (rom_select_a_switch && rom_select_b_switch) mode = MODE_ROM;
        else mode = MODE_RAM;
    end
endmodule

// file: design/bmrl_top.sv
// How it works
// - Mode comes only from three switches, sampled after power-up or reset.
// - Install switch on selects install mode, even if ROM selects disagree.
// - Install off: both selects on gives ROM mode, anything else RAM mode.
// - Install mode: indicator orange, boot dark; other modes indicator green.
// - Install mode forces stopped state regardless of the run switch.
// - Install mode disables trace capture.
// - Software install and flash writing accepted only in install mode.
// - RAM mode: boot dark, run straight from SRAM images.
// - ROM mode: boot lit, copy flash into SRAM before starting.
// - ROM mode SRAM changes are lost by reloading flash at each reset.
// - Flash write erases the user area, then copies SRAM as a batch.
// - Registration code written last, only after an error-free copy.
// - A valid registration code marks the flash contents sound.
// - Flash writes are counted; writes past endurance report an error.
// - Backup data is never copied into flash.
// - Host RAM transfers go to SRAM in all modes, in install mode only without a flash write request.
// - ROM mode online change acts next scan, replaced by flash on reset.
// - Mechanical programs and cam tables copied only for the mechanical variant.
`timescale 1ns/100ps
module bmrl_top
    import bmrl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Configuration switches
    input wire logic rom_select_a_switch,
    input wire logic rom_select_b_switch,
    input wire logic install_enable_switch,
    input wire logic run_switch,
    input wire logic mech_variant,
    // Host requests
    input wire logic flash_write_req,
    input wire logic install_active,
    input wire logic host_ram_we,
    input wire logic [ADDR_W-1:0] host_ram_addr,
    input wire logic [DATA_W-1:0] host_ram_wdata,
    // Indicators and gates
    output logic [1:0] mode_indicator,
    output logic flash_boot_indicator,
    output logic run_enable,
    output logic trace_enable,
    output logic install_enable,
    output logic [1:0] op_mode,
    // Status
    output logic busy,
    output logic flash_write_done,
    output logic write_error,
    output logic boot_error,
    output logic flash_valid,
    output logic [WCNT_W-1:0] write_count,
    // SRAM port
    output logic sram_we,
    output logic [ADDR_W-1:0] sram_addr,
    output logic [DATA_W-1:0] sram_wdata,
    input wire logic [DATA_W-1:0] sram_rdata,
    // Flash port
    output logic flash_we,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [DATA_W-1:0] flash_wdata,
    input wire logic [DATA_W-1:0] flash_rdata
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        ST_LATCH,
        ST_CODE_RD,
        ST_CHECK_CODE,
        ST_LOAD_RD,
        ST_LOAD_WR,
        ST_IDLE,
        ST_ERASE,
        ST_COPY_RD,
        ST_COPY_WAIT,
        ST_DRAIN,
        ST_REG_CODE,
        ST_HALT
    } bmrl_state_t;

    typedef struct packed {
        bmrl_state_t st;
        bmrl_mode_t mode;
        logic mech;
        logic [ADDR_W-1:0] rd_addr;
        logic rd_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic started;
        logic done;
        logic wr_err;
        logic boot_err;
        logic valid;
        logic [WCNT_W-1:0] wcnt;
        logic sram_we;
        logic [ADDR_W-1:0] sram_addr;
        logic [DATA_W-1:0] sram_wdata;
        logic flash_we;
        logic [ADDR_W-1:0] flash_addr;
        logic [DATA_W-1:0] flash_wdata;
    } bmrl_top_st_t;

    bmrl_top_st_t s_r;
    bmrl_top_st_t s_nxt;
    bmrl_mode_t sw_mode;

    // Copy stream between SRAM reads and flash writes
    logic f_in_valid;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [ADDR_W+DATA_W-1:0] f_in_data;
    logic [ADDR_W+DATA_W-1:0] f_out_data;
    logic f_flush;
    logic limit_hit;
    logic [ADDR_W-1:0] copy_last;

    ////////////////////////////////////////////////////////////////////////
    bmrl_mode_decode u_decode (
        .rom_select_a_switch(rom_select_a_switch),
        .rom_select_b_switch(rom_select_b_switch),
        .install_enable_switch(install_enable_switch),
        .mode(sw_mode)
    );

    bmrl_fifo #(
        .WIDTH(ADDR_W + DATA_W),
        .DEPTH(FIFO_DEPTH),
        .PTR_W(FIFO_PTR_W)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .flush(f_flush),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Backup region and, without the variant, mechanical data are skipped
    assign copy_last = s_r.mech ? (BACKUP_FIRST - 1'b1) : (MECH_FIRST - 1'b1);
    assign limit_hit = (s_r.wcnt >= WRITE_LIMIT);

    // SRAM read data returns one cycle after the address
    assign f_in_valid = s_r.rd_pend;
    assign f_in_data = {s_r.rd_addr, sram_rdata};
    // Drain only when the flash write stage is free
    assign f_out_ready = (s_r.st == ST_COPY_RD || s_r.st == ST_COPY_WAIT || s_r.st == ST_DRAIN) && !limit_hit;
    assign f_flush = (s_r.st == ST_IDLE);

    always_comb begin
        s_nxt = s_r;
        s_nxt.sram_we = 1'b0;
        s_nxt.flash_we = 1'b0;
        s_nxt.done = 1'b0;
        case (s_r.st)
            ST_LATCH: begin
                s_nxt.mode = sw_mode;
                s_nxt.mech = mech_variant;
                s_nxt.st = (sw_mode == MODE_ROM) ? ST_CODE_RD : ST_IDLE;
                s_nxt.started = (sw_mode == MODE_RAM);
                s_nxt.flash_addr = REG_CODE_ADDR;
            end
            ST_CODE_RD: begin
                // Code address only just presented; its word is not back yet
                s_nxt.st = ST_CHECK_CODE;
            end
            ST_CHECK_CODE: begin
                // Flash read data valid one cycle after address
                s_nxt.valid = (flash_rdata == REG_CODE_VALUE);
                if (flash_rdata == REG_CODE_VALUE) begin
                    s_nxt.st = ST_LOAD_RD;
                    s_nxt.flash_addr = USER_FIRST;
                end else begin
                    s_nxt.boot_err = 1'b1;
                    s_nxt.st = ST_HALT;
                end
            end
            ST_LOAD_RD: begin
                s_nxt.st = ST_LOAD_WR;
            end
            ST_LOAD_WR: begin
                // User area reloaded up to USER_LAST, so prior SRAM edits there vanish
                s_nxt.sram_we = 1'b1;
                s_nxt.sram_addr = s_r.flash_addr;
                s_nxt.sram_wdata = flash_rdata;
                if (s_r.flash_addr == USER_LAST) begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.started = 1'b1;
                end else begin
                    s_nxt.flash_addr = s_r.flash_addr + 1'b1;
                    s_nxt.st = ST_LOAD_RD;
                end
            end
            ST_IDLE: begin
                // Host writes reach SRAM unless a flash write is requested in install mode; flash writes only in install mode
                if (host_ram_we && s_r.mode != MODE_INSTALL || host_ram_we && !flash_write_req) begin
                    s_nxt.sram_we = 1'b1;
                    s_nxt.sram_addr = host_ram_addr;
                    s_nxt.sram_wdata = host_ram_wdata;
                end
                // Flash write refused while software install is active
                if (flash_write_req && s_r.mode == MODE_INSTALL && !install_active) begin
                    s_nxt.st = ST_ERASE;
                    s_nxt.wr_addr = USER_FIRST;
                    s_nxt.valid = 1'b0;
                end
            end
            ST_ERASE: begin
                if (limit_hit) begin
                    s_nxt.wr_err = 1'b1;
                    s_nxt.st = ST_IDLE;
                    s_nxt.done = 1'b1;
                end else begin
                    s_nxt.flash_we = 1'b1;
                    s_nxt.flash_addr = s_r.wr_addr;
                    s_nxt.flash_wdata = ERASED_VALUE;
                    s_nxt.wcnt = s_r.wcnt + 1'b1;
                    if (s_r.wr_addr == REG_CODE_ADDR) begin
                        s_nxt.st = ST_COPY_RD;
                        s_nxt.rd_addr = USER_FIRST;
                        s_nxt.sram_addr = USER_FIRST;
                    end else begin
                        s_nxt.wr_addr = s_r.wr_addr + 1'b1;
                    end
                end
            end
            ST_COPY_RD, ST_COPY_WAIT: begin
                // Read pipeline stalls on FIFO back-pressure
                if (!s_r.rd_pend || f_in_ready) begin
                    if (s_r.st == ST_COPY_RD) begin
                        s_nxt.rd_pend = 1'b1;
                        s_nxt.rd_addr = s_r.sram_addr;
                        if (s_r.sram_addr == copy_last) s_nxt.st = ST_COPY_WAIT;
                        else s_nxt.sram_addr = s_r.sram_addr + 1'b1;
                    end else begin
                        s_nxt.rd_pend = 1'b0;
                        s_nxt.st = ST_DRAIN;
                    end
                end
            end
            ST_DRAIN: begin
                if (!f_out_valid) s_nxt.st = ST_REG_CODE;
            end
            ST_REG_CODE: begin
                // Code only after a clean copy
                if (limit_hit || s_r.wr_err) begin
                    s_nxt.wr_err = 1'b1;
                end else begin
                    s_nxt.flash_we = 1'b1;
                    s_nxt.flash_addr = REG_CODE_ADDR;
                    s_nxt.flash_wdata = REG_CODE_VALUE;
                    s_nxt.wcnt = s_r.wcnt + 1'b1;
                    s_nxt.valid = 1'b1;
                end
                s_nxt.done = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            ST_HALT: begin
                s_nxt.st = ST_HALT;
            end
            default: begin
                s_nxt.st = ST_HALT;
            end
        endcase
        // Stream drain writes flash
        if (f_out_valid && f_out_ready) begin
            s_nxt.flash_we = 1'b1;
            s_nxt.flash_addr = f_out_data[ADDR_W+DATA_W-1:DATA_W];
            s_nxt.flash_wdata = f_out_data[DATA_W-1:0];
            s_nxt.wcnt = s_r.wcnt + 1'b1;
        end else if (f_out_valid && limit_hit && s_r.st != ST_IDLE) begin
            s_nxt.wr_err = 1'b1;
            s_nxt.st = ST_REG_CODE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write count cleared by every reset; no nonvolatile copy here
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
            s_r.st <= ST_LATCH;
            s_r.mode <= MODE_RAM;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        mode_indicator = (s_r.mode == MODE_INSTALL) ? IND_ORANGE : IND_GREEN;
        if (s_r.st == ST_LATCH) mode_indicator = IND_OFF;
    end
    assign flash_boot_indicator = (s_r.mode == MODE_ROM) && (s_r.st != ST_LATCH);
    assign run_enable = s_r.started && run_switch && (s_r.mode != MODE_INSTALL);
    assign trace_enable = s_r.started && (s_r.mode != MODE_INSTALL);
    assign install_enable = (s_r.mode == MODE_INSTALL) && (s_r.st != ST_LATCH);
    assign op_mode = s_r.mode;
    assign busy = (s_r.st != ST_IDLE) && (s_r.st != ST_HALT);
    assign flash_write_done = s_r.done;
    assign write_error = s_r.wr_err;
    assign boot_error = s_r.boot_err;
    assign flash_valid = s_r.valid;
    assign write_count = s_r.wcnt;
    assign sram_we = s_r.sram_we;
    assign sram_addr = s_r.sram_addr;
    assign sram_wdata = s_r.sram_wdata;
    assign flash_we = s_r.flash_we;
    assign flash_addr = s_r.flash_addr;
    assign flash_wdata = s_r.flash_wdata;
endmodule

// file: tb/bmrl_properties.sv
`timescale 1ns/100ps
module bmrl_properties
    import bmrl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Host side
    input wire logic host_ram_we,
    input wire logic [ADDR_W-1:0] host_ram_addr,
    input wire logic [DATA_W-1:0] host_ram_wdata,
    // Indicators and status
    input wire logic [1:0] mode_indicator,
    input wire logic flash_boot_indicator,
    input wire logic run_enable,
    input wire logic trace_enable,
    input wire logic [1:0] op_mode,
    input wire logic busy,
    input wire logic boot_error,
    input wire logic flash_write_done,
    // Memories
    input wire logic sram_we,
    input wire logic [ADDR_W-1:0] sram_addr,
    input wire logic [DATA_W-1:0] sram_wdata,
    input wire logic flash_we,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] flash_wdata
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    logic inst;
    logic live;
    // Indicator off only in the first cycle after reset
    assign inst = (op_mode == MODE_INSTALL);
    assign live = (mode_indicator != IND_OFF);
    ////////////////////////////////////////
    sequence s_code_wr;
        flash_we && flash_addr == REG_CODE_ADDR && flash_wdata == REG_CODE_VALUE;
    endsequence
    sequence s_done_pulse;
        flash_write_done ##1 !flash_write_done;
    endsequence
    AST_ORANGE: assert property (live && inst |-> mode_indicator == IND_ORANGE && !flash_boot_indicator)
        else $error("install indicators wrong");
    AST_GREEN: assert property (live && !inst |-> mode_indicator == IND_GREEN)
        else $error("mode indicator not green");
    AST_STOPPED: assert property (inst |-> !run_enable)
        else $error("running in install mode");
    AST_NO_TRACE: assert property (inst |-> !trace_enable)
        else $error("trace in install mode");
    AST_FLASH_BOOT_INDICATOR: assert property (live |-> flash_boot_indicator == (op_mode == MODE_ROM))
        else $error("boot indicator wrong");
    AST_MODE_HELD: assert property (live && $past(live) |-> $stable(op_mode))
        else $error("mode changed without reset");
    AST_FLASH_GATE: assert property (flash_we |-> inst)
        else $error("flash written outside install mode");
    AST_BACKUP: assert property (flash_we && flash_addr >= BACKUP_FIRST && flash_addr < REG_CODE_ADDR
        |-> flash_wdata == ERASED_VALUE)
        else $error("backup area copied");
    AST_CODE_LAST: assert property (s_code_wr |-> s_done_pulse)
        else $error("code not the final write");
    AST_HOST_SRAM: assert property (host_ram_we && live && !busy && !boot_error
        |=> sram_we && sram_addr == $past(host_ram_addr) && sram_wdata == $past(host_ram_wdata))
        else $error("host write not sent to sram");
    AST_HALTED: assert property (boot_error |-> !run_enable && !trace_enable)
        else $error("started without code");
endmodule
bind bmrl_top bmrl_properties props (.sys_clk(sys_clk), .reset(reset), .host_ram_we(host_ram_we),
    .host_ram_addr(host_ram_addr), .host_ram_wdata(host_ram_wdata), .mode_indicator(mode_indicator),
    .flash_boot_indicator(flash_boot_indicator), .run_enable(run_enable), .trace_enable(trace_enable),
    .op_mode(op_mode), .busy(busy), .boot_error(boot_error), .flash_write_done(flash_write_done),
    .sram_we(sram_we), .sram_addr(sram_addr), .sram_wdata(sram_wdata), .flash_we(flash_we),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata));

// file: tb/bmrl_mem_model.sv
`timescale 1ns/100ps
module bmrl_mem_model
    import bmrl_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // SRAM side
    input wire logic sram_we,
    input wire logic [ADDR_W-1:0] sram_addr,
    input wire logic [DATA_W-1:0] sram_wdata,
    output logic [DATA_W-1:0] sram_rdata,
    // Flash side
    input wire logic flash_we,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] flash_wdata,
    output logic [DATA_W-1:0] flash_rdata
);
    logic [DATA_W-1:0] sram_m [0:4095];
    logic [DATA_W-1:0] flash_m [0:4095];
    // Blank flash has no code, so a first ROM boot must fail
    initial begin
        for (int i = 0; i < 4096; i++) begin
            sram_m[i] = {4'h5, i[11:0]};
            flash_m[i] = 16'h0000;
        end
    end
    // Read data follows the address by one cycle
    always @(posedge sys_clk) begin
        if (sram_we) sram_m[sram_addr] <= sram_wdata;
        if (flash_we) flash_m[flash_addr] <= flash_wdata;
        sram_rdata <= sram_m[sram_addr];
        flash_rdata <= flash_m[flash_addr];
    end
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
module tb
    import bmrl_pkg::*;
();
    logic sys_clk, reset, sel_a, sel_b, inst_sw, mech, fw_req, inst_act, h_we, run_sw;
    logic [WCNT_W-1:0] wcnt;
    logic [ADDR_W-1:0] h_addr, sram_addr, flash_addr;
    logic [DATA_W-1:0] h_data, sram_wdata, sram_rdata, flash_wdata, flash_rdata;
    logic [1:0] mode_indicator, op_mode;
    logic flash_boot_indicator, run_enable, trace_enable, install_enable, busy;
    logic flash_write_done, write_error, boot_error, flash_valid, sram_we, flash_we;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    bmrl_top uut (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .rom_select_a_switch(sel_a),
        .rom_select_b_switch(sel_b), .install_enable_switch(inst_sw), .run_switch(run_sw),
        .mech_variant(mech), .flash_write_req(fw_req), .install_active(inst_act), .host_ram_we(h_we),
        .host_ram_addr(h_addr), .host_ram_wdata(h_data), .mode_indicator(mode_indicator),
        .flash_boot_indicator(flash_boot_indicator), .run_enable(run_enable), .trace_enable(trace_enable),
        .install_enable(install_enable), .op_mode(op_mode), .busy(busy), .flash_write_done(flash_write_done),
        .write_error(write_error), .boot_error(boot_error), .flash_valid(flash_valid), .write_count(wcnt),
        .sram_we(sram_we), .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_rdata(sram_rdata),
        .flash_we(flash_we), .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata));
    bmrl_mem_model mem (.sys_clk(sys_clk), .sram_we(sram_we), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
        .sram_rdata(sram_rdata), .flash_we(flash_we), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_rdata(flash_rdata));
    ////////////////////////////////////////
    task automatic compare(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // This task moves the switches only while reset is held
    task automatic rst(input logic a, input logic b, input logic i, input logic m);
        @(posedge sys_clk);
        reset <= 1'b1;
        sel_a <= a;
        sel_b <= b;
        inst_sw <= i;
        mech <= m;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        tick(4);
        while (busy === 1'b1) tick(1);
    endtask
    task automatic host_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        h_we <= 1'b1;
        h_addr <= a;
        h_data <= d;
        @(posedge sys_clk);
        h_we <= 1'b0;
        tick(2);
    endtask
    ////////////////////////////////////////
    task automatic t_modes();
        bmrl_mode_t md;
        for (int i = 0; i < 8; i++) begin
            rst(i[2], i[1], i[0], 1'b0);
            md = i[0] ? MODE_INSTALL : (i[2] && i[1]) ? MODE_ROM : MODE_RAM;
            compare("op_mode", op_mode, md);
            compare("mode_ind", mode_indicator, i[0] ? IND_ORANGE : IND_GREEN);
            compare("boot_ind", flash_boot_indicator, md == MODE_ROM);
            compare("install_en", install_enable, i[0]);
            compare("run_en", run_enable, md == MODE_RAM);
            compare("trace_en", trace_enable, md == MODE_RAM);
            compare("boot_err", boot_error, md == MODE_ROM);
            @(posedge sys_clk);
            sel_a <= ~sel_a;
            inst_sw <= ~inst_sw;
            tick(3);
            compare("held_mode", op_mode, md);
        end
        $display("test modes done");
    endtask
    task automatic t_flash();
        for (int m = 0; m < 2; m++) begin
            rst(1'b0, 1'b0, 1'b1, m[0]);
            host_wr(12'h010, 16'h1234);
            compare("sram_host", mem.sram_m[12'h010], 16'h1234);
            @(posedge sys_clk);
            inst_act <= 1'b1;
            fw_req <= 1'b1;
            tick(20);
            compare("blocked", busy, 1'b0);
            @(posedge sys_clk);
            inst_act <= 1'b0;
            @(posedge sys_clk);
            fw_req <= 1'b0;
            do tick(1); while (flash_write_done !== 1'b1);
            // Code word lands in the model one edge after the done pulse
            tick(1);
            compare("done_len", flash_write_done, 1'b0);
            compare("wr_count", wcnt, (m ? BACKUP_FIRST : MECH_FIRST) + REG_CODE_ADDR + 17'd2);
            compare("copy", mem.flash_m[12'h010], 16'h1234);
            compare("mech", mem.flash_m[MECH_FIRST], m ? 16'h5c00 : ERASED_VALUE);
            compare("backup", mem.flash_m[BACKUP_FIRST], ERASED_VALUE);
            compare("code", mem.flash_m[REG_CODE_ADDR], REG_CODE_VALUE);
            compare("valid", flash_valid, 1'b1);
            compare("wr_err", write_error, 1'b0);
        end
        $display("test flash write done");
    endtask
    task automatic t_refuse();
        rst(1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge sys_clk);
        fw_req <= 1'b1;
        tick(10);
        compare("ram_idle", busy, 1'b0);
        @(posedge sys_clk);
        fw_req <= 1'b0;
        host_wr(12'h020, 16'h0b0b);
        compare("ram_host", mem.sram_m[12'h020], 16'h0b0b);
        @(posedge sys_clk);
        run_sw <= 1'b0;
        tick(1);
        compare("run_sw_off", run_enable, 1'b0);
        @(posedge sys_clk);
        run_sw <= 1'b1;
        tick(1);
        compare("run_sw_on", run_enable, 1'b1);
        $display("test refuse done");
    endtask
    task automatic t_rom();
        rst(1'b1, 1'b1, 1'b0, 1'b1);
        compare("rom_err", boot_error, 1'b0);
        compare("rom_run", run_enable, 1'b1);
        host_wr(12'h010, 16'hbeef);
        compare("rom_host", mem.sram_m[12'h010], 16'hbeef);
        rst(1'b1, 1'b1, 1'b0, 1'b1);
        compare("reload", mem.sram_m[12'h010], 16'h1234);
        compare("reload_ram", mem.sram_m[12'h020], 16'h5020);
        $display("test rom boot done");
    endtask
    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Ceiling well above two ROM loads and two flash writes
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        reset = 1'b1;
        {sel_a, sel_b, inst_sw, mech, fw_req, inst_act, h_we} = 7'h00;
        run_sw = 1'b1;
        h_addr = 12'h000;
        h_data = 16'h0000;
        t_modes();
        t_flash();
        t_refuse();
        t_rom();
        conclude();
    end
endmodule
